// [logic/psrp_top.sv]
// pci target side: retry and prefetch on reads, ordered transfer request queue
// assumes pci-side pins are asynchronous to clk and held across a pci clock edge
`timescale 1ns/100ps
// Notes on behaviour
// - a read is answered with retry, then 32 words are prefetched
// - returned data starts at the requested word, no word dropped
// - prefetch may take any time; no timeout discards or shifts data
// - transfer requests carry the queue priority, medium unless reconfigured
// - outstanding transfer requests are counted; none issued at the limit
// - writes and reads wait in an internal queue while stalled
// - queued writes and reads issue strictly in arrival order
// - the outstanding request limit is an adjustable input setting
module psrp_top
	import psrp_pkg::*;
#(
	parameter int PEND_DEPTH = 4,
	parameter int LIMIT_W = 4
)(
	input wire logic clk,
	input wire logic srst,
	input wire logic pci_clk,
	input wire logic pci_req,
	input wire logic pci_write,
	input wire logic [31:0] pci_addr,
	input wire logic [31:0] pci_wdata,
	input wire logic pci_take,
	output logic pci_retry,
	output logic pci_ack,
	output logic pci_rd_valid,
	output logic [31:0] pci_rd_data,
	input wire logic [LIMIT_W-1:0] tr_limit,
	input wire logic [PRIO_W-1:0] prio_cfg,
	output logic dma_xfer_request_valid,
	input wire logic dma_xfer_request_ready,
	output logic dma_xfer_request_write,
	output logic [31:0] dma_xfer_request_addr,
	output logic [31:0] dma_xfer_request_wdata,
	output logic [LEN_W-1:0] dma_xfer_request_len,
	output logic [PRIO_W-1:0] dma_xfer_request_prio,
	input wire logic dma_xfer_request_done,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata,
	output logic tr_stalled
);
	localparam int PP_W = $clog2(PEND_DEPTH);
	localparam int PC_W = $clog2(PEND_DEPTH + 1);
	localparam logic [PC_W-1:0] PEND_FULL = PC_W'(PEND_DEPTH);

	// two-flop synchronisers, third flop for clock edge
	logic [67:0] s1_r, s2_r;
	logic pclk_s3_r;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_r <= '0;
			s2_r <= '0;
			pclk_s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= {pci_clk, pci_req, pci_write, pci_take, pci_addr, pci_wdata};
			s2_r <= s1_r;
			pclk_s3_r <= s2_r[67];
		end
	end
	logic pedge, req_s, write_s, take_s;
	logic [31:0] addr_s, wdata_s;
	assign pedge = s2_r[67] & ~pclk_s3_r;
	assign req_s = s2_r[66];
	assign write_s = s2_r[65];
	assign take_s = s2_r[64];
	assign addr_s = s2_r[63:32];
	assign wdata_s = s2_r[31:0];

	// state
	logic [64:0] pend_mem [PEND_DEPTH];
	logic [PP_W-1:0] pend_wp_r, pend_rp_r, pend_wp_nxt, pend_rp_nxt;
	logic [PC_W-1:0] pend_cnt_r, pend_cnt_nxt;
	logic [LIMIT_W-1:0] out_cnt_r, out_cnt_nxt;
	logic [31:0] pf_mem [PF_WORDS];
	psrp_pf_type pf_st_r, pf_st_nxt;
	logic [31:0] pf_addr_r, pf_addr_nxt;
	logic [PF_PTR_W-1:0] pf_wp_r, pf_wp_nxt, pf_rp_r, pf_rp_nxt, sent_r, sent_nxt;
	logic [31:0] b0_r, b1_r, b0_nxt, b1_nxt;
	logic [BUF_CNT_W-1:0] bcnt_r, bcnt_nxt;
	logic retry_nxt, ack_nxt, rdv_nxt, stall_nxt;
	logic tv_nxt, tw_nxt;
	logic [31:0] ta_nxt, td_nxt;
	logic [LEN_W-1:0] tl_nxt;
	logic [PRIO_W-1:0] tp_nxt;
	logic push, pop_q, issue, wr_acc, rd_q, pend_full;
	logic [64:0] push_ent, head;
	logic buf_push, buf_pop;

	assign pend_full = (pend_cnt_r == PEND_FULL);
	assign head = pend_mem[pend_rp_r];
	assign issue = !dma_xfer_request_valid && (pend_cnt_r != '0)
		&& (out_cnt_r < tr_limit);
	assign pop_q = issue;

	always_comb
	begin
		pf_st_nxt = pf_st_r;
		pf_addr_nxt = pf_addr_r;
		pf_wp_nxt = pf_wp_r;
		pf_rp_nxt = pf_rp_r;
		sent_nxt = sent_r;
		retry_nxt = 1'b0;
		ack_nxt = 1'b0;
		wr_acc = 1'b0;
		rd_q = 1'b0;
		buf_push = 1'b0;
		buf_pop = pedge && take_s && (bcnt_r != '0);
		if (pedge && req_s)
		begin
			if (write_s)
			begin
				wr_acc = !pend_full;
				ack_nxt = !pend_full;
				retry_nxt = pend_full;
			end
			else
			begin
				case (pf_st_r)
					PF_IDLE:
					begin
						retry_nxt = 1'b1;
						if (!pend_full)
						begin
							rd_q = 1'b1;
							pf_st_nxt = PF_FETCH;
							pf_addr_nxt = addr_s;
							pf_wp_nxt = '0;
						end
					end
					PF_FULL:
					begin
						if (addr_s == pf_addr_r)
						begin
							ack_nxt = 1'b1;
							pf_st_nxt = PF_SEND;
							pf_rp_nxt = '0;
							sent_nxt = '0;
						end
						else
							retry_nxt = 1'b1;
					end
					PF_FETCH:
						retry_nxt = 1'b1;
					default:
						ack_nxt = (pf_st_r == PF_SEND);
				endcase
			end
		end
		// fetch waits as long as memory takes
		if (pf_st_r == PF_FETCH && mem_rvalid)
		begin
			pf_wp_nxt = pf_wp_r + 6'h01;
			if (pf_wp_r == PF_LAST)
				pf_st_nxt = PF_FULL;
		end
		if (pf_st_r == PF_SEND)
		begin
			buf_push = (pf_rp_r < PF_END) && (bcnt_r < BUF_ENTRIES);
			if (buf_push)
				pf_rp_nxt = pf_rp_r + 6'h01;
			if (buf_pop)
			begin
				sent_nxt = sent_r + 6'h01;
				if (sent_r == PF_LAST)
					pf_st_nxt = PF_IDLE;
			end
		end
	end

	// two-entry output buffer
	always_comb
	begin
		b0_nxt = b0_r;
		b1_nxt = b1_r;
		bcnt_nxt = bcnt_r;
		case ({buf_push, buf_pop})
			2'b10:
			begin
				if (bcnt_r == '0)
					b0_nxt = pf_mem[pf_rp_r[4:0]];
				else
					b1_nxt = pf_mem[pf_rp_r[4:0]];
				bcnt_nxt = bcnt_r + 2'h1;
			end
			2'b01:
			begin
				b0_nxt = b1_r;
				bcnt_nxt = bcnt_r - 2'h1;
			end
			2'b11:
			begin
				if (bcnt_r == 2'h1)
					b0_nxt = pf_mem[pf_rp_r[4:0]];
				else
				begin
					b0_nxt = b1_r;
					b1_nxt = pf_mem[pf_rp_r[4:0]];
				end
			end
			default:
				bcnt_nxt = bcnt_r;
		endcase
		rdv_nxt = (bcnt_nxt != '0);
	end

	// arrival-order queue and transfer request issue
	always_comb
	begin
		push = wr_acc || rd_q;
		push_ent = {wr_acc, wr_acc ? addr_s : addr_s, wdata_s};
		pend_wp_nxt = push ? PP_W'(pend_wp_r + 1'b1) : pend_wp_r;
		pend_rp_nxt = pop_q ? PP_W'(pend_rp_r + 1'b1) : pend_rp_r;
		pend_cnt_nxt = PC_W'(pend_cnt_r + PC_W'(push) - PC_W'(pop_q));
		out_cnt_nxt = LIMIT_W'(out_cnt_r
			+ LIMIT_W'(dma_xfer_request_valid && dma_xfer_request_ready)
			- LIMIT_W'(dma_xfer_request_done));
		tv_nxt = dma_xfer_request_valid && !dma_xfer_request_ready;
		tw_nxt = dma_xfer_request_write;
		ta_nxt = dma_xfer_request_addr;
		td_nxt = dma_xfer_request_wdata;
		tl_nxt = dma_xfer_request_len;
		tp_nxt = dma_xfer_request_prio;
		if (issue)
		begin
			tv_nxt = 1'b1;
			tw_nxt = head[64];
			ta_nxt = head[63:32];
			td_nxt = head[31:0];
			tl_nxt = head[64] ? LEN_ONE : LEN_BURST;
			tp_nxt = prio_cfg;
		end
		stall_nxt = (pend_cnt_nxt != '0) && (out_cnt_nxt >= tr_limit);
	end

	always_ff @(posedge clk)
	begin
		if (push)
			pend_mem[pend_wp_r] <= push_ent;
		if (pf_st_r == PF_FETCH && mem_rvalid)
			pf_mem[pf_wp_r[4:0]] <= mem_rdata;
		if (srst)
		begin
			pend_wp_r <= '0;
			pend_rp_r <= '0;
			pend_cnt_r <= '0;
			out_cnt_r <= '0;
			pf_st_r <= PF_IDLE;
			pf_addr_r <= '0;
			pf_wp_r <= '0;
			pf_rp_r <= '0;
			sent_r <= '0;
			b0_r <= '0;
			b1_r <= '0;
			bcnt_r <= '0;
			pci_retry <= 1'b0;
			pci_ack <= 1'b0;
			pci_rd_valid <= 1'b0;
			pci_rd_data <= '0;
			dma_xfer_request_valid <= 1'b0;
			dma_xfer_request_write <= 1'b0;
			dma_xfer_request_addr <= '0;
			dma_xfer_request_wdata <= '0;
			dma_xfer_request_len <= '0;
			dma_xfer_request_prio <= PRIO_MEDIUM;
			tr_stalled <= 1'b0;
		end
		else
		begin
			pend_wp_r <= pend_wp_nxt;
			pend_rp_r <= pend_rp_nxt;
			pend_cnt_r <= pend_cnt_nxt;
			out_cnt_r <= out_cnt_nxt;
			pf_st_r <= pf_st_nxt;
			pf_addr_r <= pf_addr_nxt;
			pf_wp_r <= pf_wp_nxt;
			pf_rp_r <= pf_rp_nxt;
			sent_r <= sent_nxt;
			b0_r <= b0_nxt;
			b1_r <= b1_nxt;
			bcnt_r <= bcnt_nxt;
			if (pedge)
			begin
				pci_retry <= retry_nxt;
				pci_ack <= ack_nxt;
			end
			pci_rd_valid <= rdv_nxt;
			pci_rd_data <= b0_nxt;
			dma_xfer_request_valid <= tv_nxt;
			dma_xfer_request_write <= tw_nxt;
			dma_xfer_request_addr <= ta_nxt;
			dma_xfer_request_wdata <= td_nxt;
			dma_xfer_request_len <= tl_nxt;
			dma_xfer_request_prio <= tp_nxt;
			tr_stalled <= stall_nxt;
		end
	end

	// checks
	sequence s_read_idle;
		pedge && req_s && !write_s && pf_st_r == PF_IDLE && !pend_full;
	endsequence
	sequence s_last_word;
		pf_st_r == PF_FETCH && mem_rvalid && pf_wp_r == PF_LAST;
	endsequence
	a_read_retry: assert property (@(posedge clk) disable iff (srst)
		s_read_idle |=> pci_retry && pf_st_r == PF_FETCH && pf_wp_r == '0)
		else $error("read not retried into fetch");
	a_fetch_full: assert property (@(posedge clk) disable iff (srst)
		s_last_word |=> pf_st_r == PF_FULL)
		else $error("prefetch did not complete at 32 words");
	a_send_start: assert property (@(posedge clk) disable iff (srst)
		$rose(pf_st_r == PF_SEND) |-> pf_rp_r == '0 && bcnt_r == '0)
		else $error("frame does not start at requested word");
	a_no_timeout: assert property (@(posedge clk) disable iff (srst)
		pf_st_r == PF_FETCH && !mem_rvalid |=> pf_st_r == PF_FETCH && $stable(pf_wp_r))
		else $error("slow prefetch abandoned");
	a_prio_issue: assert property (@(posedge clk) disable iff (srst)
		issue |=> dma_xfer_request_prio == $past(prio_cfg) && dma_xfer_request_valid)
		else $error("request priority wrong");
	a_limit_free: assert property (@(posedge clk) disable iff (srst)
		out_cnt_r == tr_limit && dma_xfer_request_done && pend_cnt_r != '0
		&& !dma_xfer_request_valid && $stable(tr_limit) ##1 $stable(tr_limit)
		|=> dma_xfer_request_valid)
		else $error("freed slot not used");
	a_queue_hold: assert property (@(posedge clk) disable iff (srst)
		wr_acc && !pop_q |=> pend_cnt_r == $past(pend_cnt_r) + 1'b1)
		else $error("stalled write not held");
	a_order_keep: assert property (@(posedge clk) disable iff (srst)
		issue |=> dma_xfer_request_write == $past(head[64])
		&& dma_xfer_request_addr == $past(head[63:32]))
		else $error("queue issued out of order");
	a_limit_block: assert property (@(posedge clk) disable iff (srst)
		out_cnt_r >= tr_limit |-> !issue)
		else $error("request issued at limit");
endmodule

// [logic/psrp_pkg.sv]
// constants for the pci slave read prefetch block
// shared by the block and its bench; no clock or reset here
package psrp_pkg;
	localparam int PF_WORDS = 32;
	localparam int PF_PTR_W = 6;
	localparam int PRIO_W = 2;
	localparam logic [PRIO_W-1:0] PRIO_MEDIUM = 2'h1;
	localparam int LEN_W = 6;
	localparam logic [LEN_W-1:0] LEN_ONE = 6'h01;
	localparam logic [LEN_W-1:0] LEN_BURST = 6'h20;
	localparam logic [PF_PTR_W-1:0] PF_LAST = 6'h1f;
	localparam logic [PF_PTR_W-1:0] PF_END = 6'h20;
	localparam int BUF_CNT_W = 2;
	localparam logic [BUF_CNT_W-1:0] BUF_ENTRIES = 2'h2;
	typedef enum logic [3:0] {
		PF_IDLE = 4'b0001,
		PF_FETCH = 4'b0010,
		PF_FULL = 4'b0100,
		PF_SEND = 4'b1000
	} psrp_pf_type;
endpackage

// [tb/psrp_mem_model.sv]
// memory side model: takes transfer requests, serves writes and 32-word reads
// assumes the block's clock; hold withholds completions, lat delays read data
`timescale 1ns/100ps
module psrp_mem_model
	import psrp_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic valid,
	input wire logic write,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [LEN_W-1:0] len,
	input wire logic hold,
	input wire logic [15:0] lat,
	output logic ready,
	output logic done,
	output logic rvalid,
	output logic [31:0] rdata
);
	logic [31:0] mem [64];
	logic [5:0] ra;
	int left;
	int wt;
	int pend;
	initial
	begin
		for (int i = 0; i < 64; i++)
			mem[i] = 32'h5a00_0000 + i;
		{ready, done, rvalid, rdata} = '0;
		{left, wt, pend} = '0;
		ra = '0;
		forever
		begin
			@(posedge clk);
			#1;
			done = 1'b0;
			rvalid = 1'b0;
			rdata = ~rdata;
			if (srst)
			begin
				ready = 1'b0;
				left = 0;
				pend = 0;
			end
			else
			begin
				if (left != 0 && wt != 0)
					wt--;
				else if (left != 0)
				begin
					rvalid = 1'b1;
					rdata = mem[ra];
					ra++;
					left--;
					pend += (left == 0);
				end
				if (pend != 0 && !hold)
				begin
					done = 1'b1;
					pend--;
				end
				// a request is accepted with a one-cycle ready, only while no read burst is still being returned
				ready = valid && !ready && left == 0;
				if (ready && write)
				begin
					mem[addr[5:0]] = wdata;
					pend++;
				end
				else if (ready)
				begin
					left = len;
					ra = addr[5:0];
					wt = lat;
				end
			end
		end
	end
endmodule

// [tb/tb_pci_slave_read_prefetch_ordering.sv]
// bench for the pci slave read prefetch block, acting as the pci master
// assumes the memory model on the transfer request side
`timescale 1ns/100ps
module tb_pci_slave_read_prefetch_ordering
	import psrp_pkg::*;
;
	logic clk, srst, pci_clk, req, pwr, take, retry, ack, rvl, v, rdy, w, done, mrv, stalled;
	logic hold, rt, ak, hv;
	logic [31:0] addr, wdata, rdat, a, wd, mrd, hd;
	logic [31:0] shadow [64];
	logic [3:0] lim;
	logic [1:0] prio_cfg, prio;
	logic [5:0] len;
	logic [15:0] lat;
	int error_cnt, tests_run, acc;
	psrp_top uut (.clk(clk), .srst(srst), .pci_clk(pci_clk), .pci_req(req), .pci_write(pwr),
		.pci_addr(addr), .pci_wdata(wdata), .pci_take(take), .pci_retry(retry), .pci_ack(ack),
		.pci_rd_valid(rvl), .pci_rd_data(rdat), .tr_limit(lim), .prio_cfg(prio_cfg),
		.dma_xfer_request_valid(v), .dma_xfer_request_ready(rdy), .dma_xfer_request_write(w),
		.dma_xfer_request_addr(a), .dma_xfer_request_wdata(wd), .dma_xfer_request_len(len),
		.dma_xfer_request_prio(prio), .dma_xfer_request_done(done), .mem_rvalid(mrv),
		.mem_rdata(mrd), .tr_stalled(stalled));
	psrp_mem_model mdl (.clk(clk), .srst(srst), .valid(v), .write(w), .addr(a), .wdata(wd),
		.len(len), .hold(hold), .lat(lat), .ready(rdy), .done(done), .rvalid(mrv), .rdata(mrd));
	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		pci_clk = 0;
		#137;
		forever #200 pci_clk = ~pci_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk)
		if (!srst && v && rdy)
		begin
			acc++;
			chk("prio", 32'(prio_cfg), 32'(prio));
			chk("len", 32'(w ? LEN_ONE : LEN_BURST), 32'(len));
		end
	// one pci cycle: head sampled, pins held across the pci edge, answer sampled
	task automatic pci(input logic r, input logic wr_i, input logic [31:0] ad,
		input logic [31:0] d, input logic tk);
		@(posedge clk);
		#1;
		hv = rvl;
		hd = rdat;
		req = r;
		pwr = wr_i;
		addr = ad;
		wdata = d;
		take = tk;
		@(posedge pci_clk);
		repeat (5) @(posedge clk);
		#1;
		rt = retry;
		ak = ack;
		@(posedge clk);
		#1;
		req = 0;
		take = 0;
	endtask
	task automatic wr_word(input logic [31:0] ad, input logic [31:0] d);
		pci(1, 1, ad, d, 0);
		chk("write ack", 1, ak);
		shadow[ad % 64] = d;
	endtask
	task automatic frame(input logic [31:0] ad);
		int n;
		n = 0;
		do
		begin
			pci(1, 0, ad, 0, 0);
			n++;
		end
		while (ak !== 1'b1 && n < 400);
		chk("read ack", 1, ak);
		for (int i = 0; i < PF_WORDS; i++)
		begin
			pci(0, 0, 0, 0, 1);
			chk("rd_valid", 1, hv);
			chk("rd_data", shadow[(ad + i) % 64], hd);
		end
	endtask
	task automatic rd(input logic [31:0] ad);
		pci(1, 0, ad, 0, 0);
		chk("retry", 1, rt);
		frame(ad);
	endtask
	task automatic t_reset;
		repeat (2) @(posedge clk);
		#1;
		chk("retry idle", 0, 32'(retry));
		chk("valid idle", 0, 32'(v));
		chk("prio reset", 32'(PRIO_MEDIUM), 32'(prio));
	endtask
	task automatic t_slow;
		lat = 16'h00c8;
		rd(32'h9);
		lat = 16'h0000;
	endtask
	task automatic t_order;
		int b;
		lim = 4'h1;
		hold = 1;
		prio_cfg = 2'h2;
		b = acc;
		wr_word(32'h14, 32'h1111_aaaa);
		wr_word(32'h15, 32'h2222_bbbb);
		pci(1, 0, 32'h14, 0, 0);
		chk("queued read retry", 1, rt);
		chk("stalled", 1, stalled);
		chk("issued at limit", b + 1, acc);
		hold = 0;
		frame(32'h14);
		prio_cfg = PRIO_MEDIUM;
	endtask
	task automatic t_limit;
		int b;
		lim = 4'h2;
		hold = 1;
		b = acc;
		wr_word(32'h1e, 32'h3333_cccc);
		wr_word(32'h1f, 32'h4444_dddd);
		wr_word(32'h20, 32'h5555_eeee);
		chk("issued at raised limit", b + 2, acc);
		chk("stalled at raised limit", 1, stalled);
		hold = 0;
		repeat (20) @(posedge clk);
		#1;
		chk("drained", b + 3, acc);
		chk("unstalled", 0, stalled);
	endtask
	initial
	begin
		#500000;
		error_cnt++;
		summarize;
	end
	initial
	begin
		srst = 1;
		{req, pwr, take, hold} = '0;
		addr = '0;
		wdata = '0;
		lim = 4'h4;
		prio_cfg = PRIO_MEDIUM;
		lat = 16'h0000;
		acc = 0;
		for (int i = 0; i < 64; i++)
			shadow[i] = 32'h5a00_0000 + i;
		repeat (10) @(posedge clk);
		#1;
		srst = 0;
		t_reset;
		rd(32'h5);
		t_slow;
		t_order;
		t_limit;
		rd(32'h1e);
		summarize;
	end
endmodule
